/* File: verilog/tm16_regs.vh */
// register map, field positions, encodings and reset values of the timer
`ifndef TM16_REGS_VH
`define TM16_REGS_VH

// register addresses on the 6-bit i/o space
`define TM16_ADDR_CTRL_A    6'h24
`define TM16_ADDR_CTRL_B    6'h23
`define TM16_ADDR_CTRL_C    6'h22
`define TM16_ADDR_CNT_L     6'h2C
`define TM16_ADDR_CNT_H     6'h2D
`define TM16_ADDR_CMPA_L    6'h28
`define TM16_ADDR_CMPA_H    6'h29
`define TM16_ADDR_CMPB_L    6'h2A
`define TM16_ADDR_CMPB_H    6'h2B
`define TM16_ADDR_CAP_L     6'h26
`define TM16_ADDR_CAP_H     6'h27

// control a fields
`define TM16_CA_ACT_A_HI    7
`define TM16_CA_ACT_A_LO    6
`define TM16_CA_ACT_B_HI    5
`define TM16_CA_ACT_B_LO    4
`define TM16_CA_MASK        8'hF3
// control b fields
`define TM16_CB_NOISE       7
`define TM16_CB_EDGE        6
`define TM16_CB_MASK        8'hDF
// control c strobes
`define TM16_CC_FORCE_A     7
`define TM16_CC_FORCE_B     6

// reset values
`define TM16_RST_BYTE       8'h00
`define TM16_RST_WORD       16'h0000

// fixed top values and the count limits
`define TM16_TOP_8BIT       16'h00FF
`define TM16_TOP_9BIT       16'h01FF
`define TM16_TOP_10BIT      16'h03FF
`define TM16_MAX            16'hFFFF
`define TM16_BOTTOM         16'h0000

// tick source select codes
`define TM16_CS_STOP        3'h0
`define TM16_CS_DIV1        3'h1
`define TM16_CS_DIV8        3'h2
`define TM16_CS_DIV64       3'h3
`define TM16_CS_DIV256      3'h4
`define TM16_CS_DIV1024     3'h5
`define TM16_CS_EXT_FALL    3'h6
`define TM16_CS_EXT_RISE    3'h7

// output action codes
`define TM16_ACT_OFF        2'h0
`define TM16_ACT_TOGGLE     2'h1
`define TM16_ACT_CLEAR      2'h2
`define TM16_ACT_SET        2'h3

`endif

/* File: verilog/tm16_timer.v */
// 16-bit timer with two compare outputs and byte-wide register access
`timescale 1ns/1ps
// Operation
// - counter runs on i_clk; the timer tick is only a one-cycle enable
// - phase-and-frequency-correct modes load active compares at bottom
// - one shared high-byte shadow serves counter, compare and capture
// - low-byte write loads shadow high byte plus low byte together
// - counter or capture low-byte read copies that register's high byte into the shadow
// - compare register reads return high byte directly, shadow untouched
// - shadow holds its value between accesses for reuse
// - nonzero action takes over the pin; driven only if direction is out
// - non-pwm actions: off, toggle, clear, set on match
// - pwm action 01: off unless mode bit 3, then toggles channel a only
// - fast pwm: 10 clears on match sets at bottom, 11 inverse
// - fast pwm compare equal top with upper bit: only bottom action
// - dual-slope: 10 clears on up match, sets on down match; 11 inverse
// - 4-bit mode from two bits in control a and two in control b
// - mode 0000 counts to 0xFFFF, immediate compares, wrap at max
// - clear-on-match 0100 and 1100 take top from compare a or capture
// - phase correct fixed tops 0xFF, 0x1FF, 0x3FF or register tops
// - fast pwm fixed or register tops; compare update and wrap at top
// - modes 1000 and 1001 update compares and flag wrap at bottom
// - counter write blocks compare matches on the next tick
// - tick source: stop, divide 1/8/64/256/1024, pin fall or rise
// - capture input disabled while capture register is the top
`include "tm16_regs.vh"

module tm16_timer #(
  parameter DIV_W = 10
) (
  // clock and reset
  input  wire       i_clk,
  input  wire       i_rst,
  // host i/o bus
  input  wire [5:0] i_addr,
  input  wire       i_wr,
  input  wire       i_rd,
  input  wire [7:0] i_wdata,
  output wire [7:0] o_rdata,
  // pins and port logic
  input  wire       i_external_count_pin,
  input  wire       i_capture_input,
  input  wire       i_dir_a,
  input  wire       i_dir_b,
  output wire       o_wave_out_a,
  output wire       o_wave_out_b,
  output wire       o_override_a,
  output wire       o_override_b,
  output wire       o_drive_a_n,
  output wire       o_drive_b_n,
  // event pulses
  output wire       o_wrap_flag,
  output wire       o_compare_match_flag_a,
  output wire       o_compare_match_flag_b,
  output wire       o_capture_flag
);

  reg  [7:0]       ctrl_a_r;
  reg  [7:0]       ctrl_b_r;
  reg  [7:0]       shadow_r;
  reg  [7:0]       rdata_r;
  reg  [15:0]      cnt_r;
  reg  [15:0]      cmpa_buf_r;
  reg  [15:0]      cmpb_buf_r;
  reg  [15:0]      cmpa_r;
  reg  [15:0]      cmpb_r;
  reg  [15:0]      cap_r;
  reg              dir_down_r;
  reg              blk_r;
  reg  [DIV_W-1:0] div_r;
  reg              ext_s1_r;
  reg              ext_s2_r;
  reg              ext_d_r;
  reg              cap_s1_r;
  reg              cap_s2_r;
  reg  [3:0]       cap_hist_r;
  reg              cap_filt_r;
  reg              cap_d_r;
  reg              wrap_r;
  reg              cap_flag_r;
  reg  [1:0]       match_r;
  reg              tick;
  reg  [15:0]      top;
  reg  [15:0]      cnt_nxt;
  reg              dir_down_nxt;

  ////////////////////////////////////////////////////////////////////////
  // mode decode

  // mode assembled from both control registers
  wire [3:0] wgm = {ctrl_b_r[4:3], ctrl_a_r[1:0]};
  wire [2:0] cs  = ctrl_b_r[2:0];
  wire is_fast = (wgm == 4'h5) || (wgm == 4'h6) || (wgm == 4'h7) ||
                 (wgm == 4'hE) || (wgm == 4'hF);
  wire is_pc   = (wgm == 4'h1) || (wgm == 4'h2) || (wgm == 4'h3) ||
                 (wgm == 4'hA) || (wgm == 4'hB);
  wire is_pfc  = (wgm == 4'h8) || (wgm == 4'h9);
  wire is_pwm  = is_fast | is_pc | is_pfc;
  wire is_dual = is_pc | is_pfc;
  // capture register serves as top in modes 8, 10, 12 and 14
  wire cap_is_top = wgm[3] & ~wgm[0];

  // top value selected by the mode
  always @* begin
    case (wgm)
      4'h1, 4'h5: top = `TM16_TOP_8BIT;
      4'h2, 4'h6: top = `TM16_TOP_9BIT;
      4'h3, 4'h7: top = `TM16_TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: top = cmpa_r;
      4'h8, 4'hA, 4'hC, 4'hE: top = cap_r;
      default: top = `TM16_MAX;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // tick generation

  // synchronise the count pin, then remember the last settled level
  always @(posedge i_clk) begin
    if (i_rst) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_d_r  <= 1'b0;
      div_r    <= {DIV_W{1'b0}};
    end else begin
      ext_s1_r <= i_external_count_pin;
      ext_s2_r <= ext_s1_r;
      ext_d_r  <= ext_s2_r;
      div_r    <= div_r + 1'b1;
    end
  end

  // one-cycle enable from the selected source
  always @* begin
    case (cs)
      `TM16_CS_DIV1:     tick = 1'b1;
      `TM16_CS_DIV8:     tick = &div_r[2:0];
      `TM16_CS_DIV64:    tick = &div_r[5:0];
      `TM16_CS_DIV256:   tick = &div_r[7:0];
      `TM16_CS_DIV1024:  tick = &div_r[9:0];
      `TM16_CS_EXT_FALL: tick = ext_d_r & ~ext_s2_r;
      `TM16_CS_EXT_RISE: tick = ~ext_d_r & ext_s2_r;
      default:           tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // counting sequence

  wire at_top    = (cnt_r == top);
  wire at_bottom = (cnt_r == `TM16_BOTTOM) & dir_down_r;

  // next count and direction, advanced only on a tick
  always @* begin
    cnt_nxt      = cnt_r;
    dir_down_nxt = dir_down_r;
    if (tick) begin
      if (!is_dual) begin
        cnt_nxt      = at_top ? `TM16_BOTTOM : cnt_r + 16'h0001;
        dir_down_nxt = 1'b0;
      end else if (!dir_down_r) begin
        cnt_nxt      = at_top ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
        dir_down_nxt = at_top;
      end else begin
        cnt_nxt      = at_bottom ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
        dir_down_nxt = ~at_bottom;
      end
    end
  end

  // wrap flag position depends on the mode family
  wire wrap_evt = tick & (is_fast ? at_top :
                          is_dual ? at_bottom :
                          (cnt_r == `TM16_MAX));
  // double-buffered compare load moments
  wire upd_top = tick & at_top & (is_fast | is_pc);
  wire upd_bot = tick & at_bottom & is_pfc;

  ////////////////////////////////////////////////////////////////////////
  // host access decode

  wire wr_cnt_l  = i_wr & (i_addr == `TM16_ADDR_CNT_L);
  wire wr_cmpa_l = i_wr & (i_addr == `TM16_ADDR_CMPA_L);
  wire wr_cmpb_l = i_wr & (i_addr == `TM16_ADDR_CMPB_L);
  wire wr_cap_l  = i_wr & (i_addr == `TM16_ADDR_CAP_L);
  wire wr_hi     = i_wr & ((i_addr == `TM16_ADDR_CNT_H) |
                           (i_addr == `TM16_ADDR_CMPA_H) |
                           (i_addr == `TM16_ADDR_CMPB_H) |
                           (i_addr == `TM16_ADDR_CAP_H));
  wire wr_ctrl_c = i_wr & (i_addr == `TM16_ADDR_CTRL_C);
  wire [1:0] force_v = {wr_ctrl_c & i_wdata[`TM16_CC_FORCE_B],
                        wr_ctrl_c & i_wdata[`TM16_CC_FORCE_A]} &
                       {2{~is_pwm}};

  // control registers, shadow byte and read data
  always @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_a_r <= `TM16_RST_BYTE;
      ctrl_b_r <= `TM16_RST_BYTE;
      shadow_r <= `TM16_RST_BYTE;
      rdata_r  <= `TM16_RST_BYTE;
    end else begin
      if (i_wr && i_addr == `TM16_ADDR_CTRL_A)
        ctrl_a_r <= i_wdata & `TM16_CA_MASK;
      if (i_wr && i_addr == `TM16_ADDR_CTRL_B)
        ctrl_b_r <= i_wdata & `TM16_CB_MASK;
      // shadow keeps its byte until the next high write or counter or capture low read
      if (wr_hi)
        shadow_r <= i_wdata;
      if (i_rd) begin
        case (i_addr)
          `TM16_ADDR_CTRL_A: rdata_r <= ctrl_a_r;
          `TM16_ADDR_CTRL_B: rdata_r <= ctrl_b_r;
          `TM16_ADDR_CNT_L: begin
            rdata_r  <= cnt_r[7:0];
            shadow_r <= cnt_r[15:8];
          end
          `TM16_ADDR_CNT_H:  rdata_r <= shadow_r;
          `TM16_ADDR_CAP_L: begin
            rdata_r  <= cap_r[7:0];
            shadow_r <= cap_r[15:8];
          end
          `TM16_ADDR_CAP_H:  rdata_r <= shadow_r;
          `TM16_ADDR_CMPA_L: rdata_r <= cmpa_buf_r[7:0];
          `TM16_ADDR_CMPA_H: rdata_r <= cmpa_buf_r[15:8];
          `TM16_ADDR_CMPB_L: rdata_r <= cmpb_buf_r[7:0];
          `TM16_ADDR_CMPB_H: rdata_r <= cmpb_buf_r[15:8];
          default:           rdata_r <= `TM16_RST_BYTE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter, compare and capture registers

  // host low write beats the tick in the same cycle
  always @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r      <= `TM16_RST_WORD;
      dir_down_r <= 1'b0;
      blk_r      <= 1'b0;
    end else if (wr_cnt_l) begin
      cnt_r      <= {shadow_r, i_wdata};
      blk_r      <= 1'b1;
    end else begin
      cnt_r      <= cnt_nxt;
      dir_down_r <= dir_down_nxt;
      if (tick)
        blk_r <= 1'b0;
    end
  end

  // buffered compares follow host writes; active copies per mode
  always @(posedge i_clk) begin
    if (i_rst) begin
      cmpa_buf_r <= `TM16_RST_WORD;
      cmpb_buf_r <= `TM16_RST_WORD;
      cmpa_r     <= `TM16_RST_WORD;
      cmpb_r     <= `TM16_RST_WORD;
    end else begin
      if (wr_cmpa_l)
        cmpa_buf_r <= {shadow_r, i_wdata};
      if (wr_cmpb_l)
        cmpb_buf_r <= {shadow_r, i_wdata};
      if (!is_pwm || upd_top || upd_bot) begin
        cmpa_r <= cmpa_buf_r;
        cmpb_r <= cmpb_buf_r;
      end
    end
  end

  // capture input: two-stage sync, optional four-sample filter
  always @(posedge i_clk) begin
    if (i_rst) begin
      cap_s1_r   <= 1'b0;
      cap_s2_r   <= 1'b0;
      cap_hist_r <= 4'h0;
      cap_filt_r <= 1'b0;
      cap_d_r    <= 1'b0;
    end else begin
      cap_s1_r   <= i_capture_input;
      cap_s2_r   <= cap_s1_r;
      cap_hist_r <= {cap_hist_r[2:0], cap_s2_r};
      if (!ctrl_b_r[`TM16_CB_NOISE])
        cap_filt_r <= cap_s2_r;
      else if (&cap_hist_r || ~|cap_hist_r)
        cap_filt_r <= cap_hist_r[3];
      cap_d_r    <= cap_filt_r;
    end
  end

  wire cap_edge = ctrl_b_r[`TM16_CB_EDGE] ? (cap_filt_r & ~cap_d_r) :
                                            (~cap_filt_r & cap_d_r);
  wire cap_evt  = cap_edge & ~cap_is_top;

  // capture register: host write wins over a capture event
  always @(posedge i_clk) begin
    if (i_rst)
      cap_r <= `TM16_RST_WORD;
    else if (wr_cap_l)
      cap_r <= {shadow_r, i_wdata};
    else if (cap_evt)
      cap_r <= cnt_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // compare channels

  wire [3:0]  act_all = {ctrl_a_r[`TM16_CA_ACT_B_HI:`TM16_CA_ACT_B_LO],
                         ctrl_a_r[`TM16_CA_ACT_A_HI:`TM16_CA_ACT_A_LO]};
  wire [31:0] cmp_all = {cmpb_r, cmpa_r};
  wire [1:0]  dir_all = {i_dir_b, i_dir_a};
  wire [1:0]  wave_v;
  wire [1:0]  ovr_v;
  wire [1:0]  drv_n_v;
  wire [1:0]  hit_v;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ch
      wire [1:0]  act = act_all[2*g+1:2*g];
      wire [15:0] cmp = cmp_all[16*g+15:16*g];
      // a counter write removes the match of the following tick
      wire hit    = tick & (cnt_r == cmp) & ~blk_r;
      wire tog_ok = (g == 0) & wgm[3];
      wire conn   = (act != `TM16_ACT_OFF) &
                    ~(is_pwm & (act == `TM16_ACT_TOGGLE) & ~tog_ok);
      reg  oc_r;
      reg  ovr_r;
      reg  drv_n_r;
      reg  oc_nxt;

      // output latch next value per mode family
      always @* begin
        oc_nxt = oc_r;
        if (!is_pwm) begin
          if (hit || force_v[g]) begin
            case (act)
              `TM16_ACT_TOGGLE: oc_nxt = ~oc_r;
              `TM16_ACT_CLEAR:  oc_nxt = 1'b0;
              `TM16_ACT_SET:    oc_nxt = 1'b1;
              default:          oc_nxt = oc_r;
            endcase
          end
        end else if (act == `TM16_ACT_TOGGLE) begin
          if (tog_ok && hit)
            oc_nxt = ~oc_r;
        end else if (act == `TM16_ACT_OFF) begin
          oc_nxt = oc_r;
        end else if (is_fast) begin
          // bottom action outranks a match sitting on top
          if (tick && at_top)
            oc_nxt = ~act[0];
          else if (hit)
            oc_nxt = act[0];
        end else if (hit) begin
          oc_nxt = act[0] ^ dir_down_r;
        end
      end

      // latch and pin takeover
      always @(posedge i_clk) begin
        if (i_rst) begin
          oc_r    <= 1'b0;
          ovr_r   <= 1'b0;
          drv_n_r <= 1'b1;
        end else begin
          oc_r    <= oc_nxt;
          ovr_r   <= conn;
          drv_n_r <= ~(conn & dir_all[g]);
        end
      end

      assign wave_v[g]  = oc_r;
      assign ovr_v[g]   = ovr_r;
      assign drv_n_v[g] = drv_n_r;
      assign hit_v[g]   = hit;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // event pulses

  // one-cycle pulses, one clock after the causing tick or edge
  always @(posedge i_clk) begin
    if (i_rst) begin
      wrap_r     <= 1'b0;
      cap_flag_r <= 1'b0;
      match_r    <= 2'b00;
    end else begin
      wrap_r     <= wrap_evt;
      cap_flag_r <= cap_evt;
      match_r    <= hit_v;
    end
  end

  assign o_rdata                = rdata_r;
  assign o_wave_out_a           = wave_v[0];
  assign o_wave_out_b           = wave_v[1];
  assign o_override_a           = ovr_v[0];
  assign o_override_b           = ovr_v[1];
  assign o_drive_a_n            = drv_n_v[0];
  assign o_drive_b_n            = drv_n_v[1];
  assign o_wrap_flag            = wrap_r;
  assign o_compare_match_flag_a = match_r[0];
  assign o_compare_match_flag_b = match_r[1];
  assign o_capture_flag         = cap_flag_r;

endmodule

/* File: tb/tm16_props.sv */
// assertions on the timer's host bus, pin control and event pulses
`timescale 1ns/1ps
`include "tm16_regs.vh"
module tm16_props (
  // clock and reset
  input wire       i_clk,
  input wire       i_rst,
  // host bus
  input wire [5:0] i_addr,
  input wire       i_wr,
  input wire       i_rd,
  input wire [7:0] i_wdata,
  input wire [7:0] o_rdata,
  // pins and events
  input wire       i_dir_a,
  input wire       o_override_a,
  input wire       o_override_b,
  input wire       o_drive_a_n,
  input wire       o_wave_out_a,
  input wire       o_wrap_flag,
  input wire       o_compare_match_flag_a,
  input wire       o_compare_match_flag_b
);
  //////////////////////////////////////////////////////////////
  // shadow, control and compare images kept from bus traffic
  reg  [7:0]  sh_r, ca_r, cb_r;
  reg  [15:0] cma_r, cmb_r;
  reg         ok_r, oka_r, okb_r;
  reg  [2:0]  stop_r;
  wire [3:0]  mode  = {cb_r[4:3], ca_r[1:0]};
  wire        pwm   = mode != 4'h0 && mode != 4'h4 && mode != 4'hC;
  wire        con_a = ca_r[7:6] != 2'h0 && !(ca_r[7:6] == 2'h1 && pwm
                      && !mode[3]);
  wire        con_b = ca_r[5:4] != 2'h0 && !(ca_r[5:4] == 2'h1 && pwm);
  wire        rsv_b = ca_r[5:4] == 2'h1 && pwm && mode[3];
  wire        wh    = i_wr && (i_addr == `TM16_ADDR_CNT_H
                      || i_addr == `TM16_ADDR_CMPA_H
                      || i_addr == `TM16_ADDR_CMPB_H
                      || i_addr == `TM16_ADDR_CAP_H);

  // track host writes; low reads of counter or capture spoil the image
  always @(posedge i_clk) begin
    if (i_rst) begin
      sh_r   <= 8'h00;
      ca_r   <= 8'h00;
      cb_r   <= 8'h00;
      cma_r  <= 16'h0000;
      cmb_r  <= 16'h0000;
      ok_r   <= 1'b1;
      oka_r  <= 1'b1;
      okb_r  <= 1'b1;
      stop_r <= 3'h0;
    end else begin
      if (wh)
        sh_r <= i_wdata;
      ok_r <= wh | (ok_r & !(i_rd && (i_addr == `TM16_ADDR_CNT_L
              || i_addr == `TM16_ADDR_CAP_L)));
      if (i_wr && i_addr == `TM16_ADDR_CTRL_A)
        ca_r <= i_wdata;
      if (i_wr && i_addr == `TM16_ADDR_CTRL_B)
        cb_r <= i_wdata;
      if (i_wr && i_addr == `TM16_ADDR_CMPA_L) begin
        cma_r <= {sh_r, i_wdata};
        oka_r <= ok_r;
      end
      if (i_wr && i_addr == `TM16_ADDR_CMPB_L) begin
        cmb_r <= {sh_r, i_wdata};
        okb_r <= ok_r;
      end
      stop_r <= (cb_r[2:0] != 3'h0) ? 3'h0 : stop_r + {2'h0, stop_r != 3'h7};
    end
  end

  default clocking dc @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_rd(a);
    i_rd && i_addr == a;
  endsequence

  a_reset_state:
    assert property ($past(i_rst) |-> o_rdata == 8'h00 && !o_override_a
      && !o_override_b && o_drive_a_n && !o_wave_out_a && !o_wrap_flag)
      else $error("outputs not idle after reset");
  a_cmpa_high_read:
    assert property (s_rd(`TM16_ADDR_CMPA_H) && oka_r
      |=> o_rdata == cma_r[15:8]) else $error("compare a high wrong");
  a_cmpb_high_read:
    assert property (s_rd(`TM16_ADDR_CMPB_H) && okb_r
      |=> o_rdata == cmb_r[15:8]) else $error("compare b high wrong");
  a_shadow_hold:
    assert property (s_rd(`TM16_ADDR_CNT_H) && ok_r |=> o_rdata == sh_r)
      else $error("held high byte lost");
  a_pin_take_a:
    assert property (con_a == $past(con_a) && mode != 4'hD
      |-> o_override_a == con_a) else $error("pin a takeover wrong");
  a_pin_take_b:
    assert property (con_b == $past(con_b) && !rsv_b && mode != 4'hD
      |-> o_override_b == con_b) else $error("pin b takeover wrong");
  a_drive_gate_a:
    assert property (o_override_a == $past(o_override_a)
      && o_override_a == $past(o_override_a, 2) && $stable(i_dir_a)
      && i_dir_a == $past(i_dir_a, 2)
      |-> o_drive_a_n == !(o_override_a && i_dir_a))
      else $error("drive enable a wrong");
  a_stopped_quiet:
    assert property (stop_r == 3'h7 |-> !o_wrap_flag
      && !o_compare_match_flag_a && !o_compare_match_flag_b)
      else $error("event while stopped");
endmodule

/* File: tb/tm16_host.sv */
// host cpu model issuing byte accesses on the timer's i/o bus
`timescale 1ns/1ps
module tm16_host (
  // clock
  input  wire logic       i_clk,
  // i/o bus towards the timer
  output logic      [5:0] o_addr,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_wdata,
  input  wire logic [7:0] i_rdata
);
  // idle bus at time zero
  initial begin
    o_addr  = 6'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 8'h00;
  end

  // one byte write; a lone low write reuses the held high byte
  task automatic wr8(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask

  // one byte read; data is registered and taken a cycle later
  task automatic rd8(input logic [5:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    @(negedge i_clk);
    d = i_rdata;
  endtask

  // high byte first, nothing in between the two bytes
  task automatic wr16(input logic [5:0] a, input logic [15:0] v);
    wr8(a + 6'h01, v[15:8]);
    wr8(a, v[7:0]);
  endtask

  // low byte first, then the captured high byte
  task automatic rd16(input logic [5:0] a, output logic [15:0] v);
    rd8(a, v[7:0]);
    rd8(a + 6'h01, v[15:8]);
  endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for the 16-bit timer
`timescale 1ns/1ps
`include "tm16_regs.vh"
module tb;
  logic        i_clk, i_rst, ext_pin, cap_pin, dir_a, dir_b, sel_a;
  wire  [5:0]  addr;
  wire  [7:0]  wdata, rdata;
  wire         wr, rd, wave_a, wave_b, ovr_a, ovr_b, drv_a_n, drv_b_n;
  wire         wrap, flag_a, flag_b, cap_flag;
  wire         meas = sel_a ? flag_a : wrap;
  int          failures, check_count, cyc, seed, n, i, k, caps;
  logic [15:0] v, w, r;
  logic [7:0]  d;
  logic [5:0]  regs [10];
  logic [1:0]  acts [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
  logic [15:0] fexp [5] = '{16'h3, 16'h2, 16'h3, 16'h2, 16'h0};
  logic [3:0]  pm [15] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8,
                          4'h9, 4'hA, 4'hB, 4'hE, 4'hF, 4'h4, 4'h4, 4'h4};
  localparam logic [15:0] TOPA = 16'h0040;
  localparam logic [15:0] TOPI = 16'h0030;

  // 25 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  tm16_timer #(.DIV_W(10)) dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wr(wr), .i_rd(rd),
    .i_wdata(wdata), .o_rdata(rdata), .i_external_count_pin(ext_pin),
    .i_capture_input(cap_pin), .i_dir_a(dir_a), .i_dir_b(dir_b),
    .o_wave_out_a(wave_a), .o_wave_out_b(wave_b), .o_override_a(ovr_a),
    .o_override_b(ovr_b), .o_drive_a_n(drv_a_n), .o_drive_b_n(drv_b_n),
    .o_wrap_flag(wrap), .o_compare_match_flag_a(flag_a),
    .o_compare_match_flag_b(flag_b), .o_capture_flag(cap_flag));
  tm16_host host_u (.i_clk(i_clk), .o_addr(addr), .o_wr(wr), .o_rd(rd),
    .o_wdata(wdata), .i_rdata(rdata));

  //////////////////////////////////////////////////////////////
  // report counts, give the verdict and stop
  task automatic complete_run;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // compare one value
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // event period in clocks for a mode and a tick source
  function automatic logic [15:0] exp_per(input logic [3:0] m,
                                          input logic [2:0] cs);
    logic [15:0] t;
    case (m)
      4'h1, 4'h5: t = `TM16_TOP_8BIT;
      4'h2, 4'h6: t = `TM16_TOP_9BIT;
      4'h3, 4'h7: t = `TM16_TOP_10BIT;
      4'h8, 4'hA, 4'hE: t = TOPI;
      default: t = TOPA;
    endcase
    t = m[2] ? t + 16'h1 : t << 1;
    return t * (cs == 3'h2 ? 16'h8 : cs == 3'h3 ? 16'h40 : 16'h1);
  endfunction

  // stop, clear the count, set mode and action, then start
  task automatic run(input logic [3:0] m, input logic [2:0] cs,
                     input logic [1:0] act);
    host_u.wr8(`TM16_ADDR_CTRL_B, {3'h0, m[3:2], 3'h0});
    host_u.wr16(`TM16_ADDR_CNT_L, 16'h0000);
    host_u.wr8(`TM16_ADDR_CTRL_A, {act, 4'h0, m[1:0]});
    host_u.wr8(`TM16_ADDR_CTRL_B, {3'h0, m[3:2], cs});
  endtask

  // clocks between two pulses of the selected event
  task automatic per(input logic s, output int p);
    sel_a = s;
    k = 0;
    while (meas !== 1'b1 && k < 70000) begin
      @(posedge i_clk);
      k++;
    end
    p = 0;
    do begin
      @(posedge i_clk);
      p++;
    end while (meas !== 1'b1 && p < 70000);
  endtask

  // hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    caps <= caps + (cap_flag === 1'b1);
    if (cyc == 60000) begin
      failures++;
      complete_run();
    end
  end

  // main sequence
  initial begin
    seed = 32'hA496;
    i_rst = 1'b1;
    {ext_pin, cap_pin, dir_a, dir_b, sel_a} = 5'h00;
    regs = '{`TM16_ADDR_CTRL_A, `TM16_ADDR_CTRL_B, `TM16_ADDR_CNT_L,
      `TM16_ADDR_CNT_H, `TM16_ADDR_CMPA_L, `TM16_ADDR_CMPA_H,
      `TM16_ADDR_CMPB_L, `TM16_ADDR_CMPB_H, `TM16_ADDR_CAP_L,
      `TM16_ADDR_CAP_H};
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    for (i = 0; i < 10; i++) begin
      host_u.rd8(regs[i], d);
      chk("reset reg", 16'h0000, {8'h00, d});
    end
    chk("reset pins", 16'h0003, {10'h000, wave_a, wave_b, ovr_a, ovr_b,
      drv_a_n, drv_b_n});
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      w = $random(seed);
      host_u.wr16(`TM16_ADDR_CMPA_L, v);
      host_u.wr16(`TM16_ADDR_CAP_L, w);
      host_u.wr16(`TM16_ADDR_CNT_L, v ^ w);
      host_u.rd16(`TM16_ADDR_CMPA_L, r);
      chk("compare a", v, r);
      host_u.rd16(`TM16_ADDR_CAP_L, r);
      chk("capture", w, r);
      host_u.rd16(`TM16_ADDR_CNT_L, r);
      chk("count", v ^ w, r);
    end
    host_u.wr8(`TM16_ADDR_CNT_H, 8'hA5);
    host_u.wr8(`TM16_ADDR_CMPA_L, 8'h11);
    host_u.wr8(`TM16_ADDR_CMPB_L, 8'h22);
    host_u.rd16(`TM16_ADDR_CMPA_L, r);
    chk("reuse a", 16'hA511, r);
    host_u.rd16(`TM16_ADDR_CMPB_L, r);
    chk("reuse b", 16'hA522, r);
    host_u.rd8(`TM16_ADDR_CNT_H, d);
    chk("shadow kept", 16'h00A5, {8'h00, d});
    host_u.rd8(`TM16_ADDR_CNT_L, d);
    host_u.rd8(`TM16_ADDR_CAP_H, d);
    chk("shadow shared", {8'h00, v[15:8] ^ w[15:8]}, {8'h00, d});
    for (i = 0; i < 5; i++) begin
      @(posedge i_clk);
      v = $random(seed);
      dir_a <= v[0];
      dir_b <= v[1];
      host_u.wr8(`TM16_ADDR_CTRL_A, {acts[i], 6'h00});
      host_u.wr8(`TM16_ADDR_CTRL_C, 8'h80);
      repeat (2) @(posedge i_clk);
      chk("forced out", fexp[i], {14'h0, ovr_a, wave_a});
      chk("drive a", {15'h0, ~(fexp[i][1] & dir_a)}, {15'h0, drv_a_n});
    end
    host_u.wr16(`TM16_ADDR_CMPA_L, 16'h0100);
    host_u.wr8(`TM16_ADDR_CTRL_B, 8'h01);
    for (i = 0; i < 2; i++) begin
      host_u.wr16(`TM16_ADDR_CNT_L, i ? 16'h00FE : 16'h0100);
      n = 0;
      repeat (5) begin
        @(posedge i_clk);
        n += (flag_a === 1'b1);
      end
      chk("match after write", i, n[15:0]);
    end
    host_u.wr8(`TM16_ADDR_CTRL_B, 8'h00);
    host_u.wr16(`TM16_ADDR_CMPA_L, TOPA);
    host_u.wr16(`TM16_ADDR_CAP_L, TOPI);
    for (i = 0; i < 15; i++) begin
      run(pm[i], i < 12 ? 3'h1 : 3'(i - 11), 2'h0);
      per(pm[i] == 4'h4, n);
      chk("period", exp_per(pm[i], i < 12 ? 3'h1 : 3'(i - 11)),
        n[15:0]);
    end
    for (i = 0; i < 2; i++) begin
      run(4'hF, 3'h1, i ? 2'h3 : 2'h2);
      per(1'b0, n);
      k = 0;
      repeat (70) begin
        @(posedge i_clk);
        k += (wave_a !== (i == 0));
      end
      chk("match at top", 16'h0000, k[15:0]);
      run(i ? 4'h5 : 4'hF, 3'h1, 2'h1);
      repeat (2) @(posedge i_clk);
      chk("pwm toggle pin", {15'h0, i == 0}, {15'h0, ovr_a});
    end
    for (i = 0; i < 2; i++) begin
      run(i ? 4'hC : 4'h0, i ? 3'h6 : 3'h7, 2'h0);
      repeat (5) begin
        repeat (8) @(posedge i_clk);
        {ext_pin, cap_pin} <= 2'h3;
        repeat (8) @(posedge i_clk);
        {ext_pin, cap_pin} <= 2'h0;
      end
      repeat (8) @(posedge i_clk);
      host_u.wr8(`TM16_ADDR_CTRL_B, 8'h00);
      host_u.rd16(`TM16_ADDR_CNT_L, r);
      chk("pin count", 16'h0005, r);
    end
    chk("captures", 16'h0005, caps[15:0]);
    complete_run();
  end
endmodule

bind tm16_timer tm16_props chk_u (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr),
  .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_dir_a(i_dir_a),
  .o_override_a(o_override_a), .o_override_b(o_override_b),
  .o_drive_a_n(o_drive_a_n), .o_wave_out_a(o_wave_out_a),
  .o_wrap_flag(o_wrap_flag),
  .o_compare_match_flag_a(o_compare_match_flag_a),
  .o_compare_match_flag_b(o_compare_match_flag_b));
